// *** verilog/bpc_pkg.sv ***
// Shared constants for the buffered PWM counter: register map, fields, reset values.
// Assumes a 32-bit Avalon-MM slave with byte addresses and a 16-bit counter.
package bpc_pkg;

	localparam int CNT_W = 16;

	// Register byte offsets
	localparam logic [5:0] OFS_CTRL          = 6'h00;
	localparam logic [5:0] OFS_ACTION        = 6'h04;
	localparam logic [5:0] OFS_PERIOD        = 6'h08;
	localparam logic [5:0] OFS_PERIOD_SHADOW = 6'h0C;
	localparam logic [5:0] OFS_COMPARE       = 6'h10;
	localparam logic [5:0] OFS_COMPARE_SHADOW = 6'h14;
	localparam logic [5:0] OFS_COUNT         = 6'h18;
	localparam logic [5:0] OFS_CMD           = 6'h1C;
	localparam logic [5:0] OFS_STATUS        = 6'h20;

	// Control word fields
	localparam int CTRL_W         = 24;
	localparam int CTRL_ENABLE    = 0;
	localparam int CTRL_DIR_LO    = 1;
	localparam int CTRL_POL_LO    = 3;
	localparam int CTRL_STOP_KILL = 5;
	localparam int CTRL_SYNC_KILL = 6;
	localparam int CTRL_SWAP_PER  = 7;
	localparam int CTRL_SWAP_CMP  = 8;
	localparam int CTRL_SWAP_ALL  = 9;
	localparam int CTRL_PSC_LO    = 16;

	// Action word fields
	localparam int ACT_W     = 6;
	localparam int ACT_OV_LO = 0;
	localparam int ACT_UN_LO = 2;
	localparam int ACT_HIT_LO = 4;

	// Command bits
	localparam int CMD_RELOAD = 0;
	localparam int CMD_START  = 1;
	localparam int CMD_KILL   = 2;
	localparam int CMD_SWAP   = 3;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST   = 24'h00_0000;
	localparam logic [ACT_W-1:0]  ACT_RST    = 6'h3F;
	localparam logic [CNT_W-1:0]  PERIOD_RST = 16'hFFFF;
	localparam logic [CNT_W-1:0]  CMP_RST    = 16'h0000;

	typedef enum logic [1:0] {DIR_UP, DIR_DOWN, DIR_UPDN_BOTTOM, DIR_UPDN_BOTH} bpc_dir_t;
	typedef enum logic [1:0] {ACT_SET, ACT_CLEAR, ACT_INVERT, ACT_NONE} bpc_act_t;

endpackage

// *** verilog/bpc_pwm_counter.sv ***
// Buffered PWM counter channel with Avalon-MM register access and kill inputs.
// Assumes one clock, synchronous active-high reset, kill and swap pins asynchronous.
// Contract
// - Up or down: hit on entering compare
// - Up/down: hit on leaving compare
// - Underflow when decrementing leaves zero
// - Overflow when incrementing leaves period
// - Terminal event selected by direction mode
// - Each event sets, clears or inverts wave
// - Wrap action first, compare action after
// - Polarity bits invert true, complement outputs
// - Shadow writes never disturb active waveform
// - Up or down cycle lasts period+1
// - Reload starts; up/down loads one
// - Up/down reload treats prior count zero
// - Stop-on-kill halts until reload/start
// - Async kill suppresses while kill high
// - Sync kill suppresses until clean terminal
// - Terminal event swaps active and shadow
// - Constant swap trigger swaps every terminal
// - Swap event pending until terminal event; a request while stopped, or disable, clears it
// - One write swaps several grouped counters
// - Stopped: polarity levels; disabled: low
// - Pulse width follows compare value
// - No dead time between outputs
// - Count ranges per direction mode
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module bpc_pwm_counter
	import bpc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        killPin,
	input  wire logic        swapPin,
	input  wire logic        groupSwapIn,
	output logic             groupSwapOut,
	output logic             pwmTrue,
	output logic             pwmComp
);

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [ACT_W-1:0]  act;
		logic [CNT_W-1:0]  period;
		logic [CNT_W-1:0]  periodShadow;
		logic [CNT_W-1:0]  cmp;
		logic [CNT_W-1:0]  cmpShadow;
		logic [CNT_W-1:0]  count;
		logic [7:0]        psCnt;
		logic              running;
		logic              upDir;
		logic              wave;
		logic              suppress;
		logic              killPend;
		logic              swapPending;
		logic [2:0]        killSync;
		logic [2:0]        swapSync;
		logic              killLvl;
		logic              swapLvl;
		logic              ack;
		logic [31:0]       rdata;
		logic              groupSwap;
		logic              outTrue;
		logic              outComp;
	} bpc_state_t;

	bpc_state_t st;
	bpc_state_t next_st;

	logic           en;
	bpc_dir_t       dir;
	logic [1:0]     pol;
	logic           stopOnKill;
	logic           syncKill;
	logic           tick;
	logic           ovEvt;
	logic           unEvt;
	logic           hitEvt;
	logic           tcEvt;
	logic           doSwap;
	logic           wrEn;
	logic           reloadEvt;
	logic           startEvt;
	logic           killEvt;
	logic           swapReq;
	logic           killNext;
	logic           swapNext;
	logic           killRise;
	logic [CNT_W-1:0] stepCount;

	// Apply one configured action to the wave
	function automatic logic applyAct(input logic w, input logic [1:0] a);
		case (bpc_act_t'(a))
			ACT_SET:    applyAct = 1'b1;
			ACT_CLEAR:  applyAct = 1'b0;
			ACT_INVERT: applyAct = ~w;
			default:    applyAct = w;
		endcase
	endfunction

	// Merge written bytes into an old word
	function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		mergeBe = r;
	endfunction

	// Wait one cycle per request, then answer
	assign waitrequest  = (read | write) & ~st.ack;
	assign readdata     = st.rdata;
	assign groupSwapOut = st.groupSwap;
	assign pwmTrue      = st.outTrue;
	assign pwmComp      = st.outComp;

	// Next-state logic of the whole channel
	always_comb begin
		next_st    = st;
		en         = st.ctrl[CTRL_ENABLE];
		dir        = bpc_dir_t'(st.ctrl[CTRL_DIR_LO +: 2]);
		pol        = st.ctrl[CTRL_POL_LO +: 2];
		stopOnKill = st.ctrl[CTRL_STOP_KILL];
		syncKill   = st.ctrl[CTRL_SYNC_KILL];
		ovEvt      = 1'b0;
		unEvt      = 1'b0;
		hitEvt     = 1'b0;
		stepCount  = st.count;
		// Bus handshake
		next_st.ack = (read | write) & ~st.ack;
		wrEn        = write & st.ack;
		// Pin synchronisers, change taken when stages two and three agree
		next_st.killSync = {st.killSync[1:0], killPin};
		next_st.swapSync = {st.swapSync[1:0], swapPin};
		killNext = (st.killSync[1] == st.killSync[2]) ? st.killSync[2] : st.killLvl;
		swapNext = (st.swapSync[1] == st.swapSync[2]) ? st.swapSync[2] : st.swapLvl;
		next_st.killLvl = killNext;
		next_st.swapLvl = swapNext;
		killRise = killNext & ~st.killLvl;
		// Software commands
		reloadEvt = wrEn && address == OFS_CMD && byteenable[0] && writedata[CMD_RELOAD];
		startEvt  = wrEn && address == OFS_CMD && byteenable[0] && writedata[CMD_START];
		killEvt   = (wrEn && address == OFS_CMD && byteenable[0] && writedata[CMD_KILL]) || killRise;
		next_st.groupSwap = wrEn && address == OFS_CMD && byteenable[0] && writedata[CMD_SWAP];
		swapReq   = next_st.groupSwap || (swapNext & ~st.swapLvl) || groupSwapIn;
		tick = en && st.running && st.psCnt == st.ctrl[CTRL_PSC_LO +: 8];
		next_st.psCnt = (en && st.running && !tick) ? st.psCnt + 8'h01 : 8'h00;
		if (tick) begin
			case (dir)
				DIR_UP: begin
					if (st.count == st.period) begin
						ovEvt     = 1'b1;
						stepCount = '0;
					end else begin
						stepCount = st.count + 16'h0001;
					end
					hitEvt = stepCount == st.cmp;
				end
				DIR_DOWN: begin
					if (st.count == '0) begin
						unEvt     = 1'b1;
						stepCount = st.period;
					end else begin
						stepCount = st.count - 16'h0001;
					end
					hitEvt = stepCount == st.cmp;
				end
				default: begin
					if (st.upDir) begin
						if (st.count == st.period) begin
							ovEvt          = 1'b1;
							next_st.upDir  = 1'b0;
							stepCount      = st.count - 16'h0001;
						end else begin
							stepCount = st.count + 16'h0001;
						end
					end else begin
						if (st.count == '0) begin
							unEvt         = 1'b1;
							next_st.upDir = 1'b1;
							stepCount     = 16'h0001;
						end else begin
							stepCount = st.count - 16'h0001;
						end
					end
					hitEvt = st.count == st.cmp;
				end
			endcase
			next_st.count = stepCount;
		end
		case (dir)
			DIR_UP:        tcEvt = ovEvt;
			DIR_DOWN:      tcEvt = unEvt;
			DIR_UPDN_BOTH: tcEvt = ovEvt | unEvt;
			default:       tcEvt = unEvt;
		endcase
		if (tick) begin
			next_st.wave = applyAct(applyAct(applyAct(st.wave, st.act[ACT_OV_LO +: 2] | {2{~ovEvt}}),
				st.act[ACT_UN_LO +: 2] | {2{~unEvt}}), st.act[ACT_HIT_LO +: 2] | {2{~hitEvt}});
		end
		doSwap = tcEvt && (st.swapPending || st.ctrl[CTRL_SWAP_ALL]);
		if (doSwap && st.ctrl[CTRL_SWAP_PER]) begin
			next_st.period       = st.periodShadow;
			next_st.periodShadow = st.period;
		end
		if (doSwap && st.ctrl[CTRL_SWAP_CMP]) begin
			next_st.cmp       = st.cmpShadow;
			next_st.cmpShadow = st.cmp;
		end
		// request pends swap only while running, held until terminal event, set wins
		if (tcEvt) begin
			next_st.swapPending = 1'b0;
		end
		if (swapReq) begin
			next_st.swapPending = st.running;
		end
		// Kill modes
		if (stopOnKill) begin
			next_st.suppress = 1'b0;
			next_st.killPend = 1'b0;
			if (killEvt) begin
				next_st.running = 1'b0;
			end
		end else if (!syncKill) begin
			next_st.killPend = 1'b0;
			if (tick) begin
				next_st.suppress = killNext;
			end
		end else begin
			if (killRise) begin
				next_st.killPend = 1'b1;
			end
			if (tick && (st.killPend || killRise)) begin
				next_st.suppress = 1'b1;
				next_st.killPend = 1'b0;
			end else if (tcEvt && !killNext) begin
				next_st.suppress = 1'b0;
			end
		end
		if (reloadEvt) begin
			next_st.running = 1'b1;
			next_st.psCnt   = 8'h00;
			next_st.upDir   = 1'b1;
			case (dir)
				DIR_UP:   next_st.count = '0;
				DIR_DOWN: next_st.count = st.period;
				default:  next_st.count = 16'h0001;
			endcase
			if (dir == DIR_UPDN_BOTTOM || dir == DIR_UPDN_BOTH) begin
				if (st.cmp == '0) begin
					next_st.wave = applyAct(next_st.wave, st.act[ACT_HIT_LO +: 2]);
				end
			end else if (next_st.count == st.cmp) begin
				next_st.wave = applyAct(next_st.wave, st.act[ACT_HIT_LO +: 2]);
			end
		end else if (startEvt) begin
			next_st.running = 1'b1;
		end
		// Disable stops everything
		if (!en) begin
			next_st.running     = 1'b0;
			next_st.swapPending = 1'b0;
			next_st.suppress    = 1'b0;
			next_st.killPend    = 1'b0;
		end
		// shadow and active registers written by bus
		if (wrEn) begin
			case (address)
				OFS_CTRL:           next_st.ctrl = CTRL_W'(mergeBe(32'(st.ctrl), writedata, byteenable));
				OFS_ACTION:         next_st.act = ACT_W'(mergeBe(32'(st.act), writedata, byteenable));
				OFS_PERIOD:         next_st.period = CNT_W'(mergeBe(32'(st.period), writedata, byteenable));
				OFS_PERIOD_SHADOW:  next_st.periodShadow = CNT_W'(mergeBe(32'(st.periodShadow), writedata, byteenable));
				OFS_COMPARE:        next_st.cmp = CNT_W'(mergeBe(32'(st.cmp), writedata, byteenable));
				OFS_COMPARE_SHADOW: next_st.cmpShadow = CNT_W'(mergeBe(32'(st.cmpShadow), writedata, byteenable));
				default:            next_st.ctrl = next_st.ctrl;
			endcase
		end
		// Read data captured in the waiting cycle
		if (read && !st.ack) begin
			case (address)
				OFS_CTRL:           next_st.rdata = 32'(st.ctrl);
				OFS_ACTION:         next_st.rdata = 32'(st.act);
				OFS_PERIOD:         next_st.rdata = 32'(st.period);
				OFS_PERIOD_SHADOW:  next_st.rdata = 32'(st.periodShadow);
				OFS_COMPARE:        next_st.rdata = 32'(st.cmp);
				OFS_COMPARE_SHADOW: next_st.rdata = 32'(st.cmpShadow);
				OFS_COUNT:          next_st.rdata = 32'(st.count);
				OFS_STATUS:         next_st.rdata = {27'h000_0000, st.upDir, st.wave, st.swapPending, st.suppress, st.running};
				default:            next_st.rdata = 32'h0000_0000;
			endcase
		end
		// complement follows with no dead time
		if (!next_st.ctrl[CTRL_ENABLE]) begin
			next_st.outTrue = 1'b0;
			next_st.outComp = 1'b0;
		end else if (!next_st.running || next_st.suppress) begin
			next_st.outTrue = next_st.ctrl[CTRL_POL_LO];
			next_st.outComp = next_st.ctrl[CTRL_POL_LO + 1];
		end else begin
			next_st.outTrue = next_st.wave ^ next_st.ctrl[CTRL_POL_LO];
			next_st.outComp = ~next_st.wave ^ next_st.ctrl[CTRL_POL_LO + 1];
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			st              <= '0;
			st.ctrl         <= CTRL_RST;
			st.act          <= ACT_RST;
			st.period       <= PERIOD_RST;
			st.periodShadow <= PERIOD_RST;
			st.cmp          <= CMP_RST;
			st.cmpShadow    <= CMP_RST;
		end else begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	a_disabled_low: assert property (!st.ctrl[CTRL_ENABLE] |-> !pwmTrue && !pwmComp)
		else $error("outputs not low while disabled");
	a_idle_polarity: assert property (st.ctrl[CTRL_ENABLE] && (!st.running || st.suppress)
		|-> pwmTrue == pol[0] && pwmComp == pol[1])
		else $error("idle outputs differ from polarity");
	a_out_complement: assert property (st.ctrl[CTRL_ENABLE] && st.running && !st.suppress
		|-> (pwmTrue ^ pol[0]) != (pwmComp ^ pol[1]))
		else $error("outputs not complementary");
	a_up_wrap: assert property (tick && dir == DIR_UP && st.count == st.period && !reloadEvt
		|=> st.count == '0)
		else $error("up count did not wrap to zero");
	a_down_wrap: assert property (tick && dir == DIR_DOWN && st.count == '0 && !reloadEvt && !wrEn
		|=> st.count == $past(st.period))
		else $error("down count did not reload period");
	a_tc_select: assert property (tick && (dir == DIR_UP ? st.count == st.period : st.count == '0
		&& (dir == DIR_DOWN || !st.upDir)) |-> tcEvt)
		else $error("terminal event missed");
	a_swap_cmp: assert property (tcEvt && st.ctrl[CTRL_SWAP_CMP] && (st.swapPending || st.ctrl[CTRL_SWAP_ALL]) && !wrEn
		|=> st.cmp == $past(st.cmpShadow) && st.cmpShadow == $past(st.cmp))
		else $error("compare swap not done");
	a_shadow_quiet: assert property (wrEn && address == OFS_COMPARE_SHADOW && !tcEvt |=> $stable(st.cmp))
		else $error("shadow write changed active compare");
	a_kill_halt: assert property (stopOnKill && killEvt && !reloadEvt && !startEvt |=> !st.running)
		else $error("kill did not stop counter");
	a_async_follow: assert property (tick && !stopOnKill && !syncKill && !wrEn |=> st.suppress == $past(killNext))
		else $error("async suppress not following kill");
	a_updn_reload: assert property (reloadEvt && en && st.ctrl[CTRL_DIR_LO + 1] |=> st.count == 16'h0001 && st.running)
		else $error("up/down reload did not load one");
	a_pending_hold: assert property (st.swapPending && !tcEvt && en |=> st.swapPending)
		else $error("pending swap lost before terminal event");
	c_overflow: cover property (ovEvt && hitEvt);
	c_underflow: cover property (unEvt);
	c_swap: cover property (doSwap && st.swapPending);
	c_sync_kill: cover property (syncKill && st.suppress ##1 !st.suppress);

endmodule

`default_nettype wire

// *** verification/bpc_trigger_model.sv ***
// Model of the far side triggers: kill source, swap source and a neighbour's group swap.
// Assumes the bench asks for levels on the shared clock; pins move just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module bpc_trigger_model (
	input  wire logic clk,
	input  wire logic killReq,
	input  wire logic swapReq,
	input  wire logic groupReq,
	output logic      killPin,
	output logic      swapPin,
	output logic      groupSwapIn
);
	always @(posedge clk) begin
		killPin <= killReq;
	end

	always @(posedge clk) begin
		swapPin <= swapReq;
	end

	always @(posedge clk) begin
		groupSwapIn <= groupReq;
	end
endmodule

`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the buffered PWM counter: bus tasks, waveform measurements, kill and swap runs.
// Assumes the register map and one-wait-state Avalon timing of the design package.
`timescale 1ns/1ps
`default_nettype none

module testbench
	import bpc_pkg::*;
;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [5:0]  address = 6'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [3:0]  byteenable = 4'hF;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        killReq = 1'b0;
	logic        swapReq = 1'b0;
	logic        groupReq = 1'b0;
	wire logic   killPin;
	wire logic   swapPin;
	wire logic   groupSwapIn;
	logic        groupSwapOut;
	logic        pwmTrue;
	logic        pwmComp;
	logic        sawGroup = 1'b0;
	logic [1:0]  curPol = 2'b00;
	int          n_mismatch = 0;
	int          num_checks = 0;

	// Clock at 4 ns period
	always #2 clk = ~clk;

	bpc_pwm_counter bpc_pwm_counter_i (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.killPin(killPin), .swapPin(swapPin), .groupSwapIn(groupSwapIn), .groupSwapOut(groupSwapOut),
		.pwmTrue(pwmTrue), .pwmComp(pwmComp));

	bpc_trigger_model bpc_trigger_model_i (.clk(clk), .killReq(killReq), .swapReq(swapReq), .groupReq(groupReq),
		.killPin(killPin), .swapPin(swapPin), .groupSwapIn(groupSwapIn));

	// Sticky record of the group swap pulse
	always @(posedge clk) begin
		if (groupSwapOut === 1'b1) sawGroup <= 1'b1;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic [5:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk);
		address <= a;
		write <= wr;
		read <= ~wr;
		writedata <= d;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (k >= 50) chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask

	task automatic rd(input string name, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0000_0000, q);
		chk(name, e, q & m);
	endtask

	// Disable, program, enable and reload
	task automatic cfg(input logic [1:0] dir, input logic [5:0] act, input logic [15:0] per,
		input logic [15:0] cmp, input logic [1:0] pol, input logic [31:0] extra);
		wr(OFS_CTRL, {27'h0, pol, 3'h0});
		repeat (2) @(posedge clk);
		chk("pwmTrue disabled", 1'b0, pwmTrue);
		chk("pwmComp disabled", 1'b0, pwmComp);
		wr(OFS_ACTION, {26'h0, act});
		wr(OFS_PERIOD, {16'h0, per});
		wr(OFS_COMPARE, {16'h0, cmp});
		wr(OFS_CTRL, extra | {27'h0, pol, dir, 1'b1});
		wr(OFS_CMD, 32'h0000_0001);
		curPol = pol;
	endtask

	// Measure n whole cycles of pwmTrue from a rising edge; complement tracked each clock
	task automatic wave(input string name, input int n, input int eh, input int ep);
		int k;
		int c;
		int hi;
		int per;
		logic p;
		logic bad;
		k = 0;
		c = 0;
		bad = 1'b0;
		while (pwmTrue !== 1'b0 && k < 400) begin
			@(posedge clk);
			k++;
		end
		while (pwmTrue !== 1'b1 && k < 400) begin
			@(posedge clk);
			k++;
		end
		hi = 1;
		per = 1;
		p = 1'b1;
		while (c < n && k < 400) begin
			@(posedge clk);
			k++;
			if (pwmComp !== (pwmTrue ^ ~^curPol)) bad = 1'b1;
			if (pwmTrue === 1'b1 && p === 1'b0) c++;
			if (c < n) begin
				per++;
				if (pwmTrue === 1'b1) hi++;
			end
			p = pwmTrue;
		end
		chk({name, " high"}, eh, hi);
		chk({name, " period"}, ep, per);
		chk({name, " complement"}, 1'b0, bad);
	endtask

	// Both outputs hold fixed levels for 16 clocks
	task automatic steady(input string name, input logic t, input logic c);
		logic bad;
		bad = 1'b0;
		repeat (12) @(posedge clk);
		repeat (16) begin
			@(posedge clk);
			if (pwmTrue !== t || pwmComp !== c) bad = 1'b1;
		end
		chk(name, 1'b0, bad);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		$display("[FAIL] watchdog expected finish seen timeout");
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		rd("CTRL reset", OFS_CTRL, 32'hFFFF_FFFF, {8'h0, CTRL_RST});
		rd("ACTION reset", OFS_ACTION, 32'hFFFF_FFFF, {26'h0, ACT_RST});
		rd("PERIOD reset", OFS_PERIOD, 32'hFFFF_FFFF, {16'h0, PERIOD_RST});
		rd("PERIOD_SHADOW reset", OFS_PERIOD_SHADOW, 32'hFFFF_FFFF, {16'h0, PERIOD_RST});
		rd("COMPARE reset", OFS_COMPARE, 32'hFFFF_FFFF, {16'h0, CMP_RST});
		rd("COMPARE_SHADOW reset", OFS_COMPARE_SHADOW, 32'hFFFF_FFFF, {16'h0, CMP_RST});
		rd("unmapped", 6'h24, 32'hFFFF_FFFF, 32'h0000_0000);
		rd("CMD read", OFS_CMD, 32'hFFFF_FFFF, 32'h0000_0000);
		// Start counts per direction, slow prescale so the count holds still
		for (int d = 2; d < 6; d++) begin
			cfg(2'(d % 4), 6'h0F, 16'h0004, 16'h0000, 2'b00, 32'h00FF_0000);
			rd("COUNT start", OFS_COUNT, 32'hFFFF_FFFF, (d % 4 == 1) ? 4 : (d % 4 == 0) ? 0 : 1);
			if (d == 2) chk("hit at reload", 1'b1, pwmTrue);
		end
		cfg(DIR_UP, 6'h1C, 16'h0004, 16'h0002, 2'b00, 32'h0000_0000);
		wave("up", 1, 2, 5);
		cfg(DIR_DOWN, 6'h13, 16'h0004, 16'h0002, 2'b00, 32'h0000_0000);
		wave("down", 1, 2, 5);
		cfg(DIR_UPDN_BOTTOM, 6'h2F, 16'h0004, 16'h0002, 2'b00, 32'h0000_0000);
		wave("updown hit", 1, 4, 8);
		cfg(DIR_UPDN_BOTH, 6'h34, 16'h0004, 16'h0002, 2'b00, 32'h0000_0000);
		wave("updown wrap", 1, 4, 8);
		cfg(DIR_UP, 6'h0D, 16'h0004, 16'h0003, 2'b00, 32'h0000_0000);
		wave("right aligned", 1, 2, 5);
		cfg(DIR_UP, 6'h1C, 16'h0004, 16'h0002, 2'b01, 32'h0000_0000);
		wave("polarity", 1, 3, 5);
		cfg(DIR_UP, 6'h1C, 16'h0004, 16'h0002, 2'b00, 32'h0001_0000);
		wave("prescale", 1, 4, 10);
		cfg(DIR_UP, 6'h1C, 16'h0004, 16'h0000, 2'b00, 32'h0000_0000);
		steady("zero duty", 1'b0, 1'b1);
		cfg(DIR_UP, 6'h1C, 16'h0004, 16'h0005, 2'b00, 32'h0000_0000);
		steady("full duty", 1'b1, 1'b0);
		// Shadows and the three swap sources
		cfg(DIR_UP, 6'h1C, 16'h0004, 16'h0002, 2'b00, 32'h0000_0180);
		wr(OFS_PERIOD_SHADOW, 32'h0000_0006);
		wr(OFS_COMPARE_SHADOW, 32'h0000_0003);
		wave("shadow written", 2, 4, 10);
		wr(OFS_CMD, 32'h0000_0008);
		repeat (2) @(posedge clk);
		wave("cmd swap", 1, 3, 7);
		chk("groupSwapOut", 1'b1, sawGroup);
		rd("COMPARE swapped", OFS_COMPARE, 32'hFFFF_FFFF, 32'h0000_0003);
		rd("COMPARE_SHADOW swapped", OFS_COMPARE_SHADOW, 32'hFFFF_FFFF, 32'h0000_0002);
		swapReq <= 1'b1;
		repeat (4) @(posedge clk);
		swapReq <= 1'b0;
		repeat (4) @(posedge clk);
		wave("pin swap", 1, 2, 5);
		groupReq <= 1'b1;
		@(posedge clk);
		groupReq <= 1'b0;
		repeat (2) @(posedge clk);
		wave("group swap", 1, 3, 7);
		wr(OFS_CTRL, 32'h0000_0381);
		wave("swap always", 2, 5, 12);
		// Stop on kill, software then pin
		cfg(DIR_UP, 6'h1C, 16'h0004, 16'h0002, 2'b10, 32'h0000_0020);
		wr(OFS_CMD, 32'h0000_0004);
		rd("running after kill", OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
		steady("stopped levels", 1'b0, 1'b1);
		wr(OFS_CMD, 32'h0000_0002);
		rd("running after start", OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
		killReq <= 1'b1;
		repeat (10) @(posedge clk);
		rd("running after pin kill", OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
		wr(OFS_CMD, 32'h0000_0001);
		repeat (10) @(posedge clk);
		rd("running with kill held", OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
		killReq <= 1'b0;
		wave("restart", 1, 2, 5);
		// Suppress modes: async then sync
		for (int s = 0; s < 2; s++) begin
			cfg(DIR_UP, 6'h1C, 16'h0004, 16'h0002, 2'b00, s ? 32'h0000_0040 : 32'h0000_0000);
			killReq <= 1'b1;
			steady("suppressed", 1'b0, 1'b0);
			rd("running suppressed", OFS_STATUS, 32'h0000_0003, 32'h0000_0003);
			killReq <= 1'b0;
			repeat (12) @(posedge clk);
			wave("resume", 1, 2, 5);
		end
		end_of_test();
	end
endmodule

`default_nettype wire
